// >>> verilog/dsc_params.svh
// Offsets, field positions, reset values and cycle counts of the sequencer control block.
`ifndef DSC_PARAMS_SVH
`define DSC_PARAMS_SVH

// ------------------------------------------------------------
// Register word indices on the host bus
// ------------------------------------------------------------
`define DSC_IDX_RAM_TOP 4'h7
`define DSC_IDX_CFG     4'h8
`define DSC_IDX_IEN     4'h9
`define DSC_IDX_STAT    4'ha
`define DSC_IDX_TMR     4'hb
`define DSC_IDX_FIFO    4'hc

// ------------------------------------------------------------
// RAM bank pointer codes and reset values
// ------------------------------------------------------------
`define DSC_BANK_INSTR  2'h0
`define DSC_BANK_LIM1   2'h1
`define DSC_BANK_LIM2   2'h2
`define DSC_RST_WORD    16'h0000

// ------------------------------------------------------------
// Sequencer state durations in converter clocks
// ------------------------------------------------------------
`define DSC_CYC_ONE     21'd1
`define DSC_CYC_CONV12  21'd44
`define DSC_CYC_CONV8   21'd21
`define DSC_CYC_WD6     21'd5
`define DSC_CYC_WD4     21'd1
`define DSC_CYC_WD5     21'd5
`define DSC_CYC_ACQ12   21'd9
`define DSC_CYC_ACQ8    21'd2
`define DSC_CYC_LOOPADD 21'd2
`define DSC_TMR_SHIFT   5
`define DSC_CYC_CAL     21'd1024
`define DSC_CYC_AZ      21'd64
`define DSC_FIFO_DEPTH  6'd32

`endif

// >>> verilog/dsc_pkg.sv
// Types shared by the sequencer control block.
package dsc_pkg;

    // One-hot sequencer states.
    typedef enum logic [9:0] {
        ST_IDLE = 10'h001,
        ST_CAL  = 10'h002,
        ST_AZ   = 10'h004,
        ST_S0   = 10'h008,
        ST_S1   = 10'h010,
        ST_TMR  = 10'h020,
        ST_ACQ  = 10'h040,
        ST_WD6  = 10'h080,
        ST_WD4  = 10'h100,
        ST_CONV = 10'h200
    } dsc_state_t;

    typedef struct packed {
        logic [3:0] acqTime;
        logic       watchdog;
        logic       res8;
        logic       timerUse;
        logic       syncUse;
        logic [2:0] negSel;
        logic [2:0] posSel;
        logic       pause;
        logic       loopLast;
    } dsc_instr_t;

    typedef struct packed {
        logic [5:0] ignored;
        logic       upper;
        logic       sign;
        logic [7:0] mag;
    } dsc_limit_t;

    typedef struct packed {
        logic [4:0] fifoThr;
        logic [2:0] instrNum;
        logic       standbyExitIrqEn;
        logic       lowSupplyIrqEn;
        logic       pauseIrqEn;
        logic       calDoneIrqEn;
        logic       autozeroDoneIrqEn;
        logic       fifoLevelIrqEn;
        logic       instrMatchIrqEn;
        logic       limitCrossIrqEn;
    } dsc_ien_t;

    typedef struct packed {
        logic [5:0] diag;
        logic [1:0] ramPtr;
        logic       syncDir;
        logic       azEach;
        logic       chanMask;
        logic       standby;
        logic       fullCal;
        logic       autoZero;
        logic       logicReset;
        logic       start;
    } dsc_cfg_t;

    typedef struct packed {
        logic       busy;
        logic       res8;
        logic [2:0] negSel;
        logic [2:0] posSel;
    } dsc_mux_t;

endpackage

// >>> verilog/dsc_seq_ctrl.sv
// Sequencer, limit watchdog, result FIFO and control registers of the converter.
`timescale 1ns/10ps
`default_nettype none
`include "dsc_params.svh"

// How it works
// R1: Limit word: magnitude D7-D0, sign D8, selector D9.
// R2: Selector one: flag when input exceeds limit.
// R3: Selector zero: flag when input drops below.
// R4: Host parks unused limit at negative full scale.
// R5: Enable bits gate limit, FIFO, calibration interrupts.
// R6: Auto-zero and instruction-number enables; number in D10-D8.
// R7: Enables for pause, low supply, standby return.
// R8: FIFO interrupt when count reaches D15-D11 threshold.
// R9: Config D0 alone starts the sequence.
// R10: Config D1 alone resets sequencer logic.
// R11: D3 launches full calibration, D2 auto-zero.
// R12: D8 with start clear selects limit bank.
// R13: All-zero config stops the sequencer.
// R14: D6 auto-zero per conversion; D4 standby.
// R15: Chan-mask clear tags results with instruction number.
// R16: Config D7 sets sync pin direction.
// R17: Fixed state clocks: 1,1,44/21, watchdog 5,1,5.
// R18: Timer loop adds two fixed clocks.
// R19: Instruction word field layout.
// R20: After loop instruction, return to instruction 0.
// R21: Each timer count is 32 clocks.
// R22: Interrupt held while enabled status bit pending.
// R23: Host programs everything while stopped, then starts.
module dsc_seq_ctrl
    import dsc_pkg::*;
(
    input  wire logic        clk,        // Converter clock.
    input  wire logic        rst_b,      // Asynchronous reset, active low.
    input  wire logic        busWr,      // Host write strobe.
    input  wire logic        busRd,      // Host read strobe.
    input  wire logic [3:0]  busAddr,    // Register word index.
    input  wire logic [15:0] busWData,   // Host write data.
    output logic      [15:0] busRData,   // Read data, one cycle after strobe.
    input  wire logic [12:0] convResult, // Converter result, sign in bit 12.
    input  wire logic        lowSupply,  // Supply monitor warning.
    input  wire logic        syncIn,     // Sync pin level from the pad.
    output logic             syncOut,    // Sync pin drive value.
    output logic             syncOe,     // Sync pin output enable.
    output dsc_mux_t         muxOut,     // Input select and conversion busy.
    output logic             irq         // Interrupt request, active high.
);

    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    logic [15:0] instrRam_q [8];
    logic [15:0] lim1Ram_q  [8];
    logic [15:0] lim2Ram_q  [8];
    logic [15:0] fifo_q     [32];
    dsc_cfg_t    cfg_q;
    dsc_ien_t    ien_q;
    logic [15:0] timer_q;
    logic [7:0]  stat_q;
    logic [4:0]  wrPtr_q;
    logic [4:0]  rdPtr_q;
    logic [5:0]  count_q;
    logic [2:0]  ip_q;
    logic [20:0] dly_q;
    logic [20:0] dlyD;
    logic        stbyPrev_q;
    dsc_state_t  state_q;
    dsc_state_t  stD;
    logic [15:0] busRData_q;
    logic        irq_q;
    logic        syncOut_q;
    dsc_mux_t    mux_q;

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    // Instruction/limit RAM sits in the low eight words.
    wire         ramHit  = busAddr <= `DSC_IDX_RAM_TOP;
    wire [2:0]   ramIdx  = busAddr[2:0];
    wire         ramWr   = busWr && ramHit;
    wire         cfgWr   = busWr && (busAddr == `DSC_IDX_CFG);
    wire         ienWr   = busWr && (busAddr == `DSC_IDX_IEN);
    wire         tmrWr   = busWr && (busAddr == `DSC_IDX_TMR);
    wire         statRd  = busRd && (busAddr == `DSC_IDX_STAT);
    wire         fifoRd  = busRd && (busAddr == `DSC_IDX_FIFO);
    wire         logicRst = cfgWr && busWData[1];                  // R10
    wire         run     = cfg_q.start && !cfg_q.standby;          // R9 R13 R14

    // Bank pointer reaches limits only while stopped.
    wire [1:0]   bank    = cfg_q.start ? `DSC_BANK_INSTR : cfg_q.ramPtr; // R12

    // ------------------------------------------------------------
    // Current instruction and its limits
    // ------------------------------------------------------------
    dsc_instr_t  ins;
    dsc_limit_t  lim1;
    dsc_limit_t  lim2;
    assign ins  = dsc_instr_t'(instrRam_q[ip_q]);                  // R19
    assign lim1 = dsc_limit_t'(lim1Ram_q[ip_q]);                   // R1
    assign lim2 = dsc_limit_t'(lim2Ram_q[ip_q]);                   // R1

    // Limits are nine-bit two's complement so sign set, magnitude
    // zero is negative full scale and never trips a lower bound.
    wire signed [8:0] smp  = $signed({convResult[12], convResult[11:4]});
    wire signed [8:0] l1v  = $signed({lim1.sign, lim1.mag});
    wire signed [8:0] l2v  = $signed({lim2.sign, lim2.mag});
    wire hit1 = lim1.upper ? (smp > l1v) : (smp < l1v);           // R2 R3 R4
    wire hit2 = lim2.upper ? (smp > l2v) : (smp < l2v);           // R2 R3 R4

    // ------------------------------------------------------------
    // Sequencer events
    // ------------------------------------------------------------
    wire last      = dly_q == `DSC_CYC_ONE;
    wire convDone  = (state_q == ST_CONV) && last;
    wire wdDone    = convDone && ins.watchdog;
    wire resDone   = convDone && !ins.watchdog;
    wire fifoFull  = count_q == `DSC_FIFO_DEPTH;
    wire fifoEmpty = count_q == 6'd0;
    wire push      = resDone && !fifoFull;
    wire pop       = fifoRd && !fifoEmpty;
    wire calDone   = (state_q == ST_CAL) && last;
    wire azDone    = (state_q == ST_AZ) && last;
    wire pauseHit  = convDone && ins.pause;
    wire syncWait  = ins.syncUse && !cfg_q.syncDir && !syncIn;     // R16

    // Result word: instruction number or sign extension on top.
    wire [15:0] resWord = cfg_q.chanMask ?
        {{3{convResult[12]}}, convResult} : {ip_q, convResult};   // R15

    // Acquisition length grows with the programmed acquisition field.
    wire [20:0] acqCyc = (ins.res8 ? `DSC_CYC_ACQ8 : `DSC_CYC_ACQ12)
                       + {17'd0, ins.acqTime};

    // Timer wait: 32 clocks per count plus the fixed loop overhead.
    wire [20:0] tmrCyc = {timer_q, 5'd0} + `DSC_CYC_LOOPADD;      // R18 R21

    wire [7:0] evt;
    assign evt[0] = wdDone && (hit1 || hit2);                      // R2 R3
    assign evt[1] = (state_q == ST_S0) && (ip_q == ien_q.instrNum); // R6
    assign evt[2] = count_q >= {1'b0, ien_q.fifoThr};              // R8
    assign evt[3] = azDone;
    assign evt[4] = calDone;
    assign evt[5] = pauseHit;
    assign evt[6] = lowSupply;
    assign evt[7] = stbyPrev_q && !cfg_q.standby;

    // Enable bits in the low byte gate each status bit onto the line.
    wire [7:0] enMask = ien_q[7:0];                                // R5 R6 R7

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    always_comb begin
        stD  = state_q;
        dlyD = dly_q - `DSC_CYC_ONE;
        case (state_q)
            ST_IDLE: begin
                dlyD = `DSC_CYC_ONE;
                if (cfg_q.fullCal) begin
                    stD  = ST_CAL;                                 // R11
                    dlyD = `DSC_CYC_CAL;
                end else if (cfg_q.autoZero) begin
                    stD  = ST_AZ;                                  // R11
                    dlyD = `DSC_CYC_AZ;
                end else if (run) begin
                    stD  = ST_S0;                                  // R9
                end
            end
            ST_CAL: begin
                if (last) begin
                    stD = ST_IDLE;
                end
            end
            ST_S0: begin
                if (!run) begin
                    stD  = ST_IDLE;                                // R13
                    dlyD = `DSC_CYC_ONE;
                end else begin
                    stD  = ST_S1;                                  // R17
                    dlyD = `DSC_CYC_ONE;
                end
            end
            ST_S1: begin
                if (ins.timerUse) begin
                    stD  = ST_TMR;                                 // R21
                    dlyD = tmrCyc;
                end else if (cfg_q.azEach) begin
                    stD  = ST_AZ;                                  // R14
                    dlyD = `DSC_CYC_AZ;
                end else begin
                    stD  = ST_ACQ;
                    dlyD = acqCyc;
                end
            end
            ST_TMR: begin
                if (last && cfg_q.azEach) begin
                    stD  = ST_AZ;                                  // R14
                    dlyD = `DSC_CYC_AZ;
                end else if (last) begin
                    stD  = ST_ACQ;
                    dlyD = acqCyc;
                end
            end
            ST_AZ: begin
                if (last && run) begin
                    stD  = ST_ACQ;
                    dlyD = acqCyc;
                end else if (last) begin
                    stD  = ST_IDLE;
                    dlyD = `DSC_CYC_ONE;
                end
            end
            ST_ACQ: begin
                if (syncWait) begin
                    dlyD = dly_q;                                  // R16
                end else if (last && ins.watchdog) begin
                    stD  = ST_WD6;                                 // R17
                    dlyD = `DSC_CYC_WD6;
                end else if (last) begin
                    stD  = ST_CONV;                                // R17
                    dlyD = ins.res8 ? `DSC_CYC_CONV8 : `DSC_CYC_CONV12;
                end
            end
            ST_WD6: begin
                if (last) begin
                    stD  = ST_WD4;                                 // R17
                    dlyD = `DSC_CYC_WD4;
                end
            end
            ST_WD4: begin
                stD  = ST_CONV;                                    // R17
                dlyD = `DSC_CYC_WD5;
            end
            ST_CONV: begin
                if (last) begin
                    stD  = ST_S0;
                    dlyD = `DSC_CYC_ONE;
                end
            end
            default: begin
                stD  = ST_IDLE;
                dlyD = `DSC_CYC_ONE;
            end
        endcase
    end

    // ------------------------------------------------------------
    // Sequencer registers
    // ------------------------------------------------------------
    // A logic reset drops the sequencer back to idle at instruction 0.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_q <= ST_IDLE;
            dly_q   <= `DSC_CYC_ONE;
            ip_q    <= 3'd0;
        end else if (logicRst) begin
            state_q <= ST_IDLE;                                    // R10
            dly_q   <= `DSC_CYC_ONE;
            ip_q    <= 3'd0;
        end else begin
            state_q <= stD;
            dly_q   <= dlyD;
            if (convDone) begin
                ip_q <= ins.loopLast ? 3'd0 : ip_q + 3'd1;         // R20
            end
        end
    end

    // ------------------------------------------------------------
    // Host registers
    // ------------------------------------------------------------
    // Command bits self-clear when their cycle ends, auto-zero only while not running; a pause drops start.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cfg_q      <= dsc_cfg_t'(`DSC_RST_WORD);
            ien_q      <= dsc_ien_t'(`DSC_RST_WORD);
            timer_q    <= `DSC_RST_WORD;
            stbyPrev_q <= 1'b0;
        end else begin
            stbyPrev_q <= cfg_q.standby;
            if (cfgWr) begin
                cfg_q <= dsc_cfg_t'({busWData[15:2], 1'b0, busWData[0]}); // R9 R10 R13
            end else begin
                if (calDone) begin
                    cfg_q.fullCal <= 1'b0;                         // R11
                end
                if (azDone && !run) begin
                    cfg_q.autoZero <= 1'b0;                        // R11
                end
                if (pauseHit) begin
                    cfg_q.start <= 1'b0;
                end
            end
            if (ienWr) begin
                ien_q <= dsc_ien_t'(busWData);                     // R5 R6 R7 R8
            end
            if (tmrWr) begin
                timer_q <= busWData;
            end
        end
    end

    // Instruction and limit RAM writes, steered by the bank pointer.
    always_ff @(posedge clk) begin
        if (ramWr && bank == `DSC_BANK_INSTR) begin
            instrRam_q[ramIdx] <= busWData;
        end
        if (ramWr && bank == `DSC_BANK_LIM1) begin
            lim1Ram_q[ramIdx] <= busWData;                         // R12
        end
        if (ramWr && bank == `DSC_BANK_LIM2) begin
            lim2Ram_q[ramIdx] <= busWData;                         // R12
        end
        if (push) begin
            fifo_q[wrPtr_q] <= resWord;
        end
    end

    // ------------------------------------------------------------
    // FIFO pointers and interrupt status
    // ------------------------------------------------------------
    // Results arriving while full are dropped; reading empty gives zero.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wrPtr_q <= 5'd0;
            rdPtr_q <= 5'd0;
            count_q <= 6'd0;
            stat_q  <= 8'h00;
        end else if (logicRst) begin
            wrPtr_q <= 5'd0;
            rdPtr_q <= 5'd0;
            count_q <= 6'd0;
            stat_q  <= 8'h00;
        end else begin
            wrPtr_q <= wrPtr_q + {4'd0, push};
            rdPtr_q <= rdPtr_q + {4'd0, pop};
            count_q <= count_q + {5'd0, push} - {5'd0, pop};
            // A new event in the clearing read's cycle stays set.
            stat_q  <= (stat_q & ~(statRd ? stat_q : 8'h00)) | evt; // R22
        end
    end

    // ------------------------------------------------------------
    // Read data and pin outputs
    // ------------------------------------------------------------
    wire [15:0] ramRd = (bank == `DSC_BANK_LIM1) ? lim1Ram_q[ramIdx] :
                        (bank == `DSC_BANK_LIM2) ? lim2Ram_q[ramIdx] :
                        instrRam_q[ramIdx];
    wire [15:0] rdMux =
        ramHit                      ? ramRd :
        (busAddr == `DSC_IDX_CFG)  ? 16'(cfg_q) :
        (busAddr == `DSC_IDX_IEN)  ? 16'(ien_q) :
        (busAddr == `DSC_IDX_STAT) ? {8'h00, stat_q} :
        (busAddr == `DSC_IDX_TMR)  ? timer_q :
        (pop)                      ? fifo_q[rdPtr_q] :
        16'h0000;

    // All outputs are registered so pads see clean edges.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            busRData_q <= 16'h0000;
            irq_q      <= 1'b0;
            syncOut_q  <= 1'b0;
            mux_q      <= '0;
        end else begin
            busRData_q <= busRd ? rdMux : busRData_q;
            irq_q      <= |(stat_q & enMask);                      // R5 R22
            syncOut_q  <= (state_q == ST_ACQ) && ins.syncUse && cfg_q.syncDir; // R16
            mux_q.busy   <= (stD == ST_CONV);
            mux_q.res8   <= ins.res8;                              // R19
            mux_q.negSel <= ins.negSel;
            mux_q.posSel <= ins.posSel;
        end
    end

    // Direction follows the config bit one clock later, through its own flop.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            syncOe <= 1'b0;
        end else begin
            syncOe <= cfg_q.syncDir;                               // R16
        end
    end

    assign busRData = busRData_q;
    assign irq      = irq_q;
    assign syncOut  = syncOut_q;
    assign muxOut   = mux_q;

endmodule // dsc_seq_ctrl

`default_nettype wire

// >>> dv/dsc_seq_ctrl_chk.sv
// Port-level checker of the sequencer control block.
`timescale 1ns/10ps
`default_nettype none
module dsc_seq_ctrl_chk
    import dsc_pkg::*;
(
    input wire logic        clk,        // Converter clock.
    input wire logic        rst_b,      // Reset, active low.
    input wire logic        busWr,      // Write strobe.
    input wire logic        busRd,      // Read strobe.
    input wire logic [3:0]  busAddr,    // Word index.
    input wire logic [15:0] busWData,   // Write data.
    input wire logic [15:0] busRData,   // Read data.
    input wire logic [12:0] convResult, // Converter result.
    input wire logic        lowSupply,  // Supply warning.
    input wire logic        syncIn,     // Sync pad level.
    input wire logic        syncOut,    // Sync drive value.
    input wire logic        syncOe,     // Sync output enable.
    input wire dsc_mux_t    muxOut,     // Mux select and busy.
    input wire logic        irq         // Interrupt request.
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (!rst_b);

    // -------------------------------------------------------
    // Busy length counter
    // -------------------------------------------------------
    // Counts busy cycles so a conversion is judged whole when it ends.
    logic [7:0] busyCnt_q;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b)
            busyCnt_q <= 8'h00;
        else
            busyCnt_q <= muxOut.busy ? busyCnt_q + 8'h01 : 8'h00;
    end

    // -------------------------------------------------------
    // Properties
    // -------------------------------------------------------
    busy_len_a: assert property ($fell(muxOut.busy) |->
        (busyCnt_q == 8'h2c || busyCnt_q == 8'h15 || busyCnt_q == 8'h05))
        else $error("conversion length wrong");
    unmapped_rd_a: assert property (busRd && busAddr >= 4'hd |=> busRData == 16'h0000)
        else $error("unmapped read not zero");
    rdata_hold_a: assert property (!busRd && !busWr |=> $stable(busRData))
        else $error("read data moved without a read");
    sync_dir_set_a: assert property (busWr && busAddr == 4'h8 && busWData[7] && !busWData[1]
        |-> ##[1:2] syncOe) else $error("sync enable not set");
    sync_dir_clr_a: assert property (busWr && busAddr == 4'h8 && !busWData[7]
        |-> ##[1:2] !syncOe) else $error("sync enable not cleared");
    sync_out_gate_a: assert property (syncOut |-> syncOe)
        else $error("sync driven in input mode");
    logic_rst_a: assert property (busWr && busAddr == 4'h8 && busWData[1]
        |-> ##3 !muxOut.busy[*4]) else $error("logic reset left a conversion");
    irq_off_a: assert property (busWr && busAddr == 4'h9 && busWData[7:0] == 8'h00
        |-> ##3 !irq) else $error("interrupt with all enables clear");
endmodule // dsc_seq_ctrl_chk
`default_nettype wire

// >>> dv/dsc_host_model.sv
// Host processor model that writes and reads the control registers.
`timescale 1ns/10ps
`default_nettype none
module dsc_host_model (
    input  wire logic        clk,      // Converter clock.
    output logic             busWr,    // Write strobe.
    output logic             busRd,    // Read strobe.
    output logic      [3:0]  busAddr,  // Word index.
    output logic      [15:0] busWData, // Write data.
    input  wire logic [15:0] busRData  // Read data.
);
    // Strobes rise 1 ns after an edge and drop 1 ns after the edge that takes them.
    initial begin
        busWr = 1'b0;
        busRd = 1'b0;
        busAddr = 4'h0;
        busWData = 16'h0000;
    end

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        #1;
        busWr = 1'b1;
        busAddr = a;
        busWData = d;
        @(posedge clk);
        #1;
        busWr = 1'b0;
        busWData = ~d;
    endtask

    // Read data is valid once the edge that takes the strobe has passed.
    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        @(posedge clk);
        #1;
        busRd = 1'b1;
        busAddr = a;
        @(posedge clk);
        #1;
        busRd = 1'b0;
        d = busRData;
    endtask
endmodule // dsc_host_model
`default_nettype wire

// >>> dv/tb_dsc_seq_ctrl.sv
// Self-checking testbench of the sequencer control block.
`timescale 1ns/10ps
`default_nettype none
module tb_dsc_seq_ctrl;
    import dsc_pkg::*;
    logic        clk, rst_b, busWr, busRd, lowSupply, syncIn, syncOut, syncOe, irq;
    logic [3:0]  busAddr;
    logic [15:0] busWData, busRData, rdv, n;
    logic [12:0] convResult;
    dsc_mux_t    muxOut;
    int          err_count = 0;
    int          n_tests = 0;
    int          cycles = 0;
    logic [15:0] ienv [2] = '{16'hf015, 16'h07aa};
    logic [15:0] iw [2] = '{16'h0201, 16'h0401};
    logic [15:0] pre [2] = '{16'h002e, 16'h0005};
    logic [15:0] len [2] = '{16'h002c, 16'h0015};

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    dsc_host_model host (.clk(clk), .busWr(busWr), .busRd(busRd), .busAddr(busAddr),
        .busWData(busWData), .busRData(busRData));
    dsc_seq_ctrl dut (.clk(clk), .rst_b(rst_b), .busWr(busWr), .busRd(busRd),
        .busAddr(busAddr), .busWData(busWData), .busRData(busRData), .convResult(convResult),
        .lowSupply(lowSupply), .syncIn(syncIn), .syncOut(syncOut), .syncOe(syncOe),
        .muxOut(muxOut), .irq(irq));

    // -------------------------------------------------------
    // Checking and reporting
    // -------------------------------------------------------
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic final_report();
        $display("Comparisons %0d, mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic rdc(input logic [3:0] a, input logic [15:0] e);
        host.rd(a, rdv);
        chk(rdv, e);
    endtask

    // A hang is cut short well past the roughly 1500 cycles the run needs.
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            err_count++;
            final_report();
        end
    end

    // -------------------------------------------------------
    // Main sequence
    // -------------------------------------------------------
    initial begin
        rst_b = 1'b0;
        convResult = 13'h1123;
        lowSupply = 1'b0;
        syncIn = 1'b0;
        repeat (16) @(posedge clk);
        #1 rst_b = 1'b1;
        rdc(4'h8, 16'h0000);
        rdc(4'h9, 16'h0000);
        rdc(4'hb, 16'h0000);
        rdc(4'hd, 16'h0000);
        for (int i = 0; i < 2; i++) begin
            host.wr(4'h9, ienv[i]);
            rdc(4'h9, ienv[i]);
        end
        host.wr(4'h8, 16'h0100);
        host.wr(4'h0, 16'h0100);
        rdc(4'h0, 16'h0100);
        rdc(4'h8, 16'h0100);
        host.wr(4'h8, 16'h0080);
        repeat (3) @(posedge clk);
        #1 chk({15'h0000, syncOe}, 16'h0001);
        host.wr(4'h8, 16'h0000);
        host.wr(4'h9, 16'h0040);
        lowSupply = 1'b1;
        repeat (3) @(posedge clk);
        #1 lowSupply = 1'b0;
        chk({15'h0000, irq}, 16'h0001);
        host.rd(4'ha, rdv);
        chk(rdv & 16'h0040, 16'h0040);
        repeat (2) @(posedge clk);
        #1 chk({15'h0000, irq}, 16'h0000);
        host.wr(4'h8, 16'h0008);
        repeat (1030) @(posedge clk);
        host.rd(4'ha, rdv);
        chk(rdv & 16'h0010, 16'h0010);
        host.wr(4'hb, 16'h0001);
        // One looping conversion per resolution, each from a fresh logic reset.
        for (int i = 0; i < 2; i++) begin
            host.wr(4'h8, 16'h0002);
            rdc(4'h8, 16'h0000);
            host.wr(4'h9, 16'h0804);
            host.wr(4'h0, iw[i]);
            host.wr(4'h8, 16'h0001);
            n = 16'h0000;
            while (!muxOut.busy && n < 16'd500) begin
                @(posedge clk);
                #1 n++;
            end
            chk(n, pre[i]);
            n = 16'h0000;
            while (muxOut.busy && n < 16'd100) begin
                @(posedge clk);
                #1 n++;
            end
            chk(n, len[i]);
            chk({15'h0000, muxOut.res8}, 16'(i));
            repeat (4) @(posedge clk);
            #1 chk({15'h0000, irq}, 16'h0001);
            host.wr(4'h9, 16'h0000);
            host.wr(4'h8, 16'h0000);
            repeat (120) @(posedge clk);
            #1 chk({15'h0000, muxOut.busy}, 16'h0000);
            rdc(4'hc, 16'h1123);
            rdc(4'hc, 16'h1123);
        end
        final_report();
    end
endmodule // tb_dsc_seq_ctrl

bind dsc_seq_ctrl dsc_seq_ctrl_chk chk (.clk(clk), .rst_b(rst_b), .busWr(busWr), .busRd(busRd),
    .busAddr(busAddr), .busWData(busWData), .busRData(busRData), .convResult(convResult),
    .lowSupply(lowSupply), .syncIn(syncIn), .syncOut(syncOut), .syncOe(syncOe),
    .muxOut(muxOut), .irq(irq));
`default_nettype wire
